// File: hw/epvu_regs.svh
// register offsets, field positions, reset values and vector numbers
`ifndef EPVU_REGS_SVH
`define EPVU_REGS_SVH

`define EPVU_OFF_SYSCTL 12'h000
`define EPVU_OFF_MODECTL 12'h004
`define EPVU_OFF_PORTFN1 12'h008
`define EPVU_OFF_STATUS 12'h00c

`define EPVU_SYSCTL_INTM_HI 5
`define EPVU_SYSCTL_INTM_LO 4
`define EPVU_SYSCTL_RSTSRC 3
`define EPVU_SYSCTL_NMIEDGE 2
`define EPVU_SYSCTL_RSVD1 1
`define EPVU_SYSCTL_RAMEN 0
`define EPVU_SYSCTL_RST 8'h09

`define EPVU_MODECTL_EXPAND 7
`define EPVU_MODECTL_RST 8'h00

`define EPVU_PORTFN1_AHI 2
`define EPVU_PORTFN1_AMID 1
`define EPVU_PORTFN1_ALO 0
`define EPVU_PORTFN1_RST 8'h00

`define EPVU_VEC_RESET 8'h00
`define EPVU_VEC_NMI 8'h07
`define EPVU_VEC_TRAP_BASE 8'h08
`define EPVU_VEC_IRQ_BASE 8'h10
`define EPVU_VEC_PERIPH_BASE 8'h18

`define EPVU_ADDR_W 24

`endif

// File: hw/epvu_pkg.sv
// types shared by the exception and vector unit
package epvu_pkg;
	typedef enum logic [3:0] {
		EPVU_ST_RESET = 4'b0001,
		EPVU_ST_EXEC = 4'b0010,
		EPVU_ST_FETCH = 4'b0100,
		EPVU_ST_LOAD = 4'b1000
	} epvu_state_t;

	typedef enum logic [1:0] {
		EPVU_KIND_RESET = 2'b00,
		EPVU_KIND_INT = 2'b01,
		EPVU_KIND_TRAP = 2'b10
	} epvu_kind_t;
endpackage

// File: hw/epvu_edge_det.sv
// selectable edge detector for the non-maskable interrupt input
`timescale 1ns/1ns
module epvu_edge_det (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic sig_i,
	input wire logic rising_i,
	output logic edge_o
);
	logic prev_r;
	logic prev_nxt;

	always_comb begin
		prev_nxt = sig_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	// 0 selects falling, 1 selects rising
	assign edge_o = rising_i ? (sig_i & ~prev_r) : (~sig_i & prev_r);
endmodule

// File: hw/epvu_top.sv
// exception priority, vector fetch and system control registers
// Function
// - reset source flag reads 0 after watchdog reset, 1 after pin reset
// - nmi edge select resets 0; 0 falling edge, 1 rising edge
// - ram enable: 0 off, 1 on; returns to 1 when reset ends
// - advanced mode gives 24-bit addresses and keeps on-chip rom enabled
// - every reset enters single-chip mode without external space
// - in extended mode ports 6 and 7 leave reset as inputs
// - in extended mode ports 6 and 7 drive address when high, mid, low enables set
// - extended mode: ports 5, 8 data bus; ports 9, A control
// - priority reset, interrupt, trap; simultaneous ones served in order
// - reset handling starts on pin rising or watchdog overflow
// - interrupts accepted only at instruction or exception handling end
// - no interrupt detection after ccr logic/load ops or reset handling
// - trap requests accepted unconditionally while executing program
// - each source has a four-byte vector at four times its number
// - reset is vector 0 at address 0; nmi is vector 7
// - four trap sources use vectors 8 to 11 from address 0x20
// - irq 0 to 7 use vectors 16 to 23; peripherals from 24
// - interrupt mode field 00 is mode 0, 01 mode 1, others prohibited
// - after reset all interrupts, nmi too, wait for first instruction
// - reset handling sets ccr interrupt mask before vector fetch
// - trap picks one of four vectors by its two-bit number
`timescale 1ns/1ns
`include "epvu_regs.svh"
module epvu_top
	import epvu_pkg::*;
#(
	parameter int N_PERIPH = 8
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic chip_init_pin_n_i,
	input wire logic wdt_overflow_i,
	input wire logic nmi_i,
	input wire logic [7:0] irq_i,
	input wire logic [7:0] irq_level_i,
	input wire logic [N_PERIPH-1:0] periph_irq_i,
	input wire logic [N_PERIPH-1:0] periph_level_i,
	input wire logic instr_done_i,
	input wire logic instr_ccr_op_i,
	input wire logic trap_instruction_i,
	input wire logic [1:0] trap_num_i,
	input wire logic ccr_mask_i,
	input wire logic ccr_ui_i,
	output logic vec_rd_o,
	output logic [`EPVU_ADDR_W-1:0] vec_addr_o,
	input wire logic [31:0] vec_rdata_i,
	input wire logic vec_rvalid_i,
	output logic pc_load_o,
	output logic [`EPVU_ADDR_W-1:0] pc_value_o,
	output logic [1:0] exc_kind_o,
	output logic [7:0] vec_num_o,
	output logic ccr_set_mask_o,
	output logic int_ack_o,
	output logic cpu_in_reset_o,
	output logic ram_enable_o,
	output logic rom_enable_o,
	output logic ext_space_en_o,
	output logic [2:0] addr_out_en_o,
	output logic data_bus_en_o,
	output logic bus_ctrl_en_o,
	output logic irq_mode_o
);
	localparam int NS = 8 + N_PERIPH;

	// lowest index wins; irq and peripheral vectors are contiguous
	function automatic logic [7:0] epvu_pick(input logic [NS-1:0] v);
		logic [7:0] idx;
		idx = 8'h00;
		for (int i = NS - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 8'(i);
			end
		end
		return idx;
	endfunction

	epvu_state_t state_r, state_nxt;
	epvu_kind_t kind_r, kind_nxt;
	logic [7:0] vec_r, vec_nxt;
	logic [`EPVU_ADDR_W-1:0] addr_r, addr_nxt;
	logic [`EPVU_ADDR_W-1:0] pc_r, pc_nxt;
	logic nmi_pend_r, nmi_pend_nxt;
	logic trap_pend_r, trap_pend_nxt;
	logic [1:0] trap_num_r, trap_num_nxt;
	logic block_r, block_nxt;

	logic intm_lo_r, intm_lo_nxt;
	logic rstsrc_r, rstsrc_nxt;
	logic nmiedge_r, nmiedge_nxt;
	logic rsvd1_r, rsvd1_nxt;
	logic ramen_r, ramen_nxt;
	logic expand_r, expand_nxt;
	logic [2:0] addr_en_r, addr_en_nxt;
	logic rom_en_r, rom_en_nxt;
	logic [31:0] prdata_r, prdata_nxt;

	logic nmi_edge;
	logic go_reset;
	logic reset_exit;
	logic [NS-1:0] src_req, src_lvl, pool_all, pool_lvl;
	logic maskable_ok;
	logic int_avail;
	logic [7:0] int_vec;
	logic take_int_exec;
	logic take_trap;
	logic apb_wr;
	logic apb_setup;
	logic addr_hit;
	logic [7:0] sysctl_view;

	epvu_edge_det u_nmi_edge (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.sig_i(nmi_i),
		.rising_i(nmiedge_r),
		.edge_o(nmi_edge)
	);

	// pin low, block reset or watchdog overflow all force the reset state
	assign go_reset = reset_i | ~chip_init_pin_n_i | wdt_overflow_i;
	assign reset_exit = (state_r == EPVU_ST_RESET) & ~go_reset;

	assign src_req = {periph_irq_i, irq_i};
	assign src_lvl = {periph_level_i, irq_level_i};

	// mode 1 with mask set still admits level-1 sources unless ui is set
	always_comb begin
		pool_all = '0;
		pool_lvl = '0;
		if (!intm_lo_r) begin
			if (!ccr_mask_i) begin
				pool_all = src_req;
			end
		end else begin
			if (!ccr_mask_i) begin
				pool_all = src_req;
				pool_lvl = src_req & src_lvl;
			end else if (!ccr_ui_i) begin
				pool_all = src_req & src_lvl;
				pool_lvl = src_req & src_lvl;
			end
		end
	end

	assign maskable_ok = |pool_all;
	assign int_avail = (nmi_pend_r | maskable_ok) & ~block_r;

	// nmi first, then level-1 sources in mode 1, then the rest by index
	always_comb begin
		if (nmi_pend_r) begin
			int_vec = `EPVU_VEC_NMI;
		end else if (|pool_lvl) begin
			int_vec = `EPVU_VEC_IRQ_BASE + epvu_pick(pool_lvl);
		end else begin
			int_vec = `EPVU_VEC_IRQ_BASE + epvu_pick(pool_all);
		end
	end

	// ccr logic and load ops suppress detection at their own boundary
	assign take_int_exec = (state_r == EPVU_ST_EXEC) & instr_done_i &
		~instr_ccr_op_i & int_avail;
	assign take_trap = (state_r == EPVU_ST_EXEC) & ~take_int_exec &
		(trap_pend_r | trap_instruction_i);

	always_comb begin
		state_nxt = state_r;
		kind_nxt = kind_r;
		vec_nxt = vec_r;
		addr_nxt = addr_r;
		pc_nxt = pc_r;
		case (state_r)
			EPVU_ST_RESET: begin
				if (reset_exit) begin
					state_nxt = EPVU_ST_FETCH;
					kind_nxt = EPVU_KIND_RESET;
					vec_nxt = `EPVU_VEC_RESET;
				end
			end
			EPVU_ST_EXEC: begin
				// interrupt outranks a trap that arrives at the same boundary
				if (take_int_exec) begin
					state_nxt = EPVU_ST_FETCH;
					kind_nxt = EPVU_KIND_INT;
					vec_nxt = int_vec;
				end else if (take_trap) begin
					state_nxt = EPVU_ST_FETCH;
					kind_nxt = EPVU_KIND_TRAP;
					vec_nxt = `EPVU_VEC_TRAP_BASE + {6'h00, trap_pend_r ?
						trap_num_r : trap_num_i};
				end
			end
			EPVU_ST_FETCH: begin
				if (vec_rvalid_i) begin
					state_nxt = EPVU_ST_LOAD;
					pc_nxt = vec_rdata_i[`EPVU_ADDR_W-1:0];
				end
			end
			EPVU_ST_LOAD: begin
				// end of exception handling is itself a boundary, not after reset
				if (kind_r != EPVU_KIND_RESET && int_avail) begin
					state_nxt = EPVU_ST_FETCH;
					kind_nxt = EPVU_KIND_INT;
					vec_nxt = int_vec;
				end else begin
					state_nxt = EPVU_ST_EXEC;
				end
			end
			default: begin
				state_nxt = EPVU_ST_RESET;
			end
		endcase
		if (go_reset) begin
			state_nxt = EPVU_ST_RESET;
		end
		addr_nxt = {14'h0000, vec_nxt, 2'b00};
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_r <= EPVU_ST_RESET;
			kind_r <= EPVU_KIND_RESET;
			vec_r <= `EPVU_VEC_RESET;
			addr_r <= '0;
			pc_r <= '0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			vec_r <= vec_nxt;
			addr_r <= addr_nxt;
			pc_r <= pc_nxt;
		end
	end

	// pending latches: a new request in the clearing cycle survives
	always_comb begin
		nmi_pend_nxt = nmi_pend_r;
		trap_pend_nxt = trap_pend_r;
		trap_num_nxt = trap_num_r;
		block_nxt = block_r;
		if (state_nxt == EPVU_ST_FETCH && kind_nxt == EPVU_KIND_INT &&
			vec_nxt == `EPVU_VEC_NMI && state_r != EPVU_ST_FETCH) begin
			nmi_pend_nxt = 1'b0;
		end
		if (nmi_edge) begin
			nmi_pend_nxt = 1'b1;
		end
		if (take_trap) begin
			trap_pend_nxt = 1'b0;
		end
		// a trap arriving while the pending one is taken must not be lost
		if (trap_instruction_i && (trap_pend_r || !take_trap)) begin
			trap_pend_nxt = 1'b1;
			trap_num_nxt = trap_num_i;
		end
		if (state_r == EPVU_ST_EXEC && instr_done_i) begin
			block_nxt = 1'b0;
		end
		if (go_reset) begin
			nmi_pend_nxt = 1'b0;
			trap_pend_nxt = 1'b0;
			block_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			nmi_pend_r <= 1'b0;
			trap_pend_r <= 1'b0;
			trap_num_r <= 2'b00;
			block_r <= 1'b1;
		end else begin
			nmi_pend_r <= nmi_pend_nxt;
			trap_pend_r <= trap_pend_nxt;
			trap_num_r <= trap_num_nxt;
			block_r <= block_nxt;
		end
	end

	assign apb_setup = psel_i & ~penable_i;
	assign apb_wr = psel_i & penable_i & pwrite_i;
	assign addr_hit = (paddr_i == `EPVU_OFF_SYSCTL) ||
		(paddr_i == `EPVU_OFF_MODECTL) ||
		(paddr_i == `EPVU_OFF_PORTFN1) ||
		(paddr_i == `EPVU_OFF_STATUS);

	// interrupt mode high bit is read-only 0, so 1x codes never arise
	assign sysctl_view = {2'b00, 1'b0, intm_lo_r, rstsrc_r, nmiedge_r,
		rsvd1_r, ramen_r};

	always_comb begin
		intm_lo_nxt = intm_lo_r;
		rstsrc_nxt = rstsrc_r;
		nmiedge_nxt = nmiedge_r;
		rsvd1_nxt = rsvd1_r;
		ramen_nxt = ramen_r;
		expand_nxt = expand_r;
		addr_en_nxt = addr_en_r;
		rom_en_nxt = 1'b1;
		if (apb_wr && paddr_i == `EPVU_OFF_SYSCTL) begin
			intm_lo_nxt = pwdata_i[`EPVU_SYSCTL_INTM_LO];
			nmiedge_nxt = pwdata_i[`EPVU_SYSCTL_NMIEDGE];
			// stored as written; software is expected to keep it 0
			rsvd1_nxt = pwdata_i[`EPVU_SYSCTL_RSVD1];
			ramen_nxt = pwdata_i[`EPVU_SYSCTL_RAMEN];
		end
		if (apb_wr && paddr_i == `EPVU_OFF_MODECTL) begin
			expand_nxt = pwdata_i[`EPVU_MODECTL_EXPAND];
		end
		if (apb_wr && paddr_i == `EPVU_OFF_PORTFN1) begin
			addr_en_nxt = {pwdata_i[`EPVU_PORTFN1_AHI],
				pwdata_i[`EPVU_PORTFN1_AMID],
				pwdata_i[`EPVU_PORTFN1_ALO]};
		end
		// a chip reset reinitialises everything but the source flag
		if (go_reset) begin
			intm_lo_nxt = 1'b0;
			nmiedge_nxt = 1'b0;
			rsvd1_nxt = 1'b0;
			ramen_nxt = 1'b1;
			expand_nxt = 1'b0;
			addr_en_nxt = 3'b000;
		end
		if (reset_exit) begin
			ramen_nxt = 1'b1;
		end
		// watchdog wins when it overlaps a pin reset
		if (reset_i || !chip_init_pin_n_i) begin
			rstsrc_nxt = 1'b1;
		end
		if (wdt_overflow_i) begin
			rstsrc_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			intm_lo_r <= 1'b0;
			rstsrc_r <= 1'b1;
			nmiedge_r <= 1'b0;
			rsvd1_r <= 1'b0;
			ramen_r <= 1'b1;
			expand_r <= 1'b0;
			addr_en_r <= 3'b000;
			rom_en_r <= 1'b1;
		end else begin
			intm_lo_r <= intm_lo_nxt;
			rstsrc_r <= rstsrc_nxt;
			nmiedge_r <= nmiedge_nxt;
			rsvd1_r <= rsvd1_nxt;
			ramen_r <= ramen_nxt;
			expand_r <= expand_nxt;
			addr_en_r <= addr_en_nxt;
			rom_en_r <= rom_en_nxt;
		end
	end

	// read data is captured in the setup cycle so the access needs no wait
	always_comb begin
		prdata_nxt = prdata_r;
		if (apb_setup) begin
			prdata_nxt = 32'h0000_0000;
			case (paddr_i)
				`EPVU_OFF_SYSCTL: begin
					prdata_nxt = {24'h00_0000, sysctl_view};
				end
				`EPVU_OFF_MODECTL: begin
					prdata_nxt = {24'h00_0000, expand_r, 7'h00};
				end
				`EPVU_OFF_PORTFN1: begin
					prdata_nxt = {29'h0000_0000, addr_en_r};
				end
				`EPVU_OFF_STATUS: begin
					prdata_nxt = {9'h000, block_r, trap_pend_r, nmi_pend_r,
						2'b00, kind_r, vec_r, 4'h0, state_r};
				end
				default: begin
					prdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~addr_hit;

	assign vec_rd_o = (state_r == EPVU_ST_FETCH);
	assign vec_addr_o = addr_r;
	assign pc_load_o = (state_r == EPVU_ST_LOAD);
	assign pc_value_o = pc_r;
	assign exc_kind_o = kind_r;
	assign vec_num_o = vec_r;
	// mask is raised in the cycle the fetch is entered, ahead of the read
	assign ccr_set_mask_o = (state_nxt == EPVU_ST_FETCH) &
		(state_r != EPVU_ST_FETCH);
	assign int_ack_o = (state_r == EPVU_ST_LOAD) &
		(kind_r == EPVU_KIND_INT) & (vec_r != `EPVU_VEC_NMI);
	assign cpu_in_reset_o = (state_r == EPVU_ST_RESET);
	assign ram_enable_o = ramen_r;
	assign rom_enable_o = rom_en_r;
	assign ext_space_en_o = expand_r;
	assign addr_out_en_o = expand_r ? addr_en_r : 3'b000;
	assign data_bus_en_o = expand_r;
	assign bus_ctrl_en_o = expand_r;
	assign irq_mode_o = intm_lo_r;
endmodule

// File: tb/epvu_vec_mem.sv
// vector table memory seen by the exception unit, with variable latency
`timescale 1ns/1ns
module epvu_vec_mem (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] lat_i,
	input wire logic vec_rd_i,
	input wire logic [23:0] vec_addr_i,
	output logic [31:0] vec_rdata_o = 32'h0000_0000,
	output logic vec_rvalid_o = 1'b0
);
	int cnt = 0;
	always @(posedge ref_clk_i) begin
		vec_rvalid_o <= 1'b0;
		// released bus toggles every cycle, so it shows the last longword only every other cycle
		vec_rdata_o <= ~vec_rdata_o;
		if (reset_i) begin
			cnt <= 0;
		end else if (vec_rd_i && !vec_rvalid_o) begin
			if (cnt >= int'(lat_i)) begin
				vec_rvalid_o <= 1'b1;
				vec_rdata_o <= {8'hc3, 24'h10_0000 | vec_addr_i};
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// File: tb/epvu_top_monitor.sv
// port assertions for the exception and vector unit
`timescale 1ns/1ns
`include "epvu_regs.svh"
module epvu_top_monitor (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic chip_init_pin_n_i,
	input wire logic wdt_overflow_i,
	input wire logic vec_rd_o,
	input wire logic [`EPVU_ADDR_W-1:0] vec_addr_o,
	input wire logic [31:0] vec_rdata_i,
	input wire logic vec_rvalid_i,
	input wire logic pc_load_o,
	input wire logic [`EPVU_ADDR_W-1:0] pc_value_o,
	input wire logic [1:0] exc_kind_o,
	input wire logic [7:0] vec_num_o,
	input wire logic ccr_set_mask_o,
	input wire logic int_ack_o,
	input wire logic cpu_in_reset_o,
	input wire logic ram_enable_o,
	input wire logic rom_enable_o,
	input wire logic ext_space_en_o,
	input wire logic [2:0] addr_out_en_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// a new reset would legally cut any sequence short
	wire logic quiet = chip_init_pin_n_i && !wdt_overflow_i;
	wire logic [23:0] rd_lo = vec_rdata_i[23:0];
	pin_reset_a: assert property (!chip_init_pin_n_i |=> cpu_in_reset_o)
		else $error("pin low without reset state");
	fetch_hold_a: assert property (vec_rd_o && !vec_rvalid_i && quiet
		|=> vec_rd_o && $stable(vec_addr_o)) else $error("fetch dropped");
	pc_load_a: assert property (vec_rd_o && vec_rvalid_i && quiet
		|=> pc_load_o && pc_value_o == $past(rd_lo)) else $error("bad pc");
	vec_addr_a: assert property (vec_rd_o |->
		vec_addr_o == `EPVU_ADDR_W'({vec_num_o, 2'b00}))
		else $error("vector address not four times number");
	reset_vec_a: assert property (vec_rd_o && exc_kind_o == 2'b00
		|-> vec_num_o == 8'h00) else $error("reset vector not 0");
	trap_vec_a: assert property (vec_rd_o && exc_kind_o == 2'b10
		|-> vec_num_o inside {[8'h08:8'h0b]}) else $error("trap vector");
	int_ack_a: assert property (int_ack_o |-> pc_load_o &&
		exc_kind_o == 2'b01 && vec_num_o >= 8'h10) else $error("bad ack");
	mask_first_a: assert property (ccr_set_mask_o && quiet |=> vec_rd_o)
		else $error("mask set without vector fetch");
	addr_en_a: assert property (addr_out_en_o != 3'b000 |-> ext_space_en_o)
		else $error("address drive outside expansion");
	single_chip_a: assert property (cpu_in_reset_o |-> !ext_space_en_o &&
		ram_enable_o && rom_enable_o) else $error("reset state mode");
endmodule
bind epvu_top epvu_top_monitor u_mon (.ref_clk_i(ref_clk_i),
	.reset_i(reset_i), .chip_init_pin_n_i(chip_init_pin_n_i),
	.wdt_overflow_i(wdt_overflow_i), .vec_rd_o(vec_rd_o),
	.vec_addr_o(vec_addr_o), .vec_rdata_i(vec_rdata_i),
	.vec_rvalid_i(vec_rvalid_i), .pc_load_o(pc_load_o),
	.pc_value_o(pc_value_o), .exc_kind_o(exc_kind_o), .vec_num_o(vec_num_o),
	.ccr_set_mask_o(ccr_set_mask_o), .int_ack_o(int_ack_o),
	.cpu_in_reset_o(cpu_in_reset_o), .ram_enable_o(ram_enable_o),
	.rom_enable_o(rom_enable_o), .ext_space_en_o(ext_space_en_o),
	.addr_out_en_o(addr_out_en_o));

// File: tb/tb_exception_priority_vector_unit.sv
// self-checking bench for the exception and vector unit
`timescale 1ns/1ns
`include "epvu_regs.svh"
module tb_exception_priority_vector_unit;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pin_n = 1, wdt = 0;
	logic nmi = 0, done = 0, ccrop = 0, trap = 0, mask = 0;
	logic [7:0] pirq_r = 8'h00, pirq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [1:0] tnum = 2'b00;
	logic [3:0] lat = 4'h0;
	logic [7:0] irq_r = 8'h00, irq, vnum;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, vrd, vvalid, pcl, ccrm, ack, inrst, ramen, romen;
	logic exten, dben, bcen, imode;
	logic [23:0] vaddr, pcv;
	logic [1:0] kind;
	logic [2:0] aoe;
	int failures = 0, checks = 0;
	always #4 clk = ~clk;
	// a source drops its request as soon as it is acknowledged
	assign irq = irq_r & ~(ack ? 8'h01 << (vnum - 8'h10) : 8'h00);
	always @(posedge clk) if (ack) irq_r <= irq;
	assign pirq = pirq_r & ~(ack ? 8'h01 << (vnum - 8'h18) : 8'h00);
	always @(posedge clk) if (ack) pirq_r <= pirq;
	epvu_top #(.N_PERIPH(8)) uut (.ref_clk_i(clk), .reset_i(rst),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .chip_init_pin_n_i(pin_n), .wdt_overflow_i(wdt),
		.nmi_i(nmi), .irq_i(irq), .irq_level_i(8'h00), .periph_irq_i(pirq),
		.periph_level_i(8'h00), .instr_done_i(done), .instr_ccr_op_i(ccrop),
		.trap_instruction_i(trap), .trap_num_i(tnum), .ccr_mask_i(mask),
		.ccr_ui_i(1'b0), .vec_rd_o(vrd), .vec_addr_o(vaddr),
		.vec_rdata_i(rdata), .vec_rvalid_i(vvalid), .pc_load_o(pcl),
		.pc_value_o(pcv), .exc_kind_o(kind), .vec_num_o(vnum),
		.ccr_set_mask_o(ccrm), .int_ack_o(ack), .cpu_in_reset_o(inrst),
		.ram_enable_o(ramen), .rom_enable_o(romen), .ext_space_en_o(exten),
		.addr_out_en_o(aoe), .data_bus_en_o(dben), .bus_ctrl_en_o(bcen),
		.irq_mode_o(imode));
	epvu_vec_mem mem (.ref_clk_i(clk), .reset_i(rst), .lat_i(lat),
		.vec_rd_i(vrd), .vec_addr_i(vaddr), .vec_rdata_o(rdata),
		.vec_rvalid_o(vvalid));
	task automatic final_report();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) failures++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		cmp(q, x);
		cmp(32'(e), 32'(xe));
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic run_exc(input logic [7:0] num, input logic [1:0] k);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (vrd !== 1'b1 && n < 40);
		cmp(32'(vrd), 32'h0000_0001);
		cmp(32'(vaddr), {22'h00_0000, num, 2'b00});
		do begin
			@(negedge clk);
			n++;
		end while (pcl !== 1'b1 && n < 80);
		cmp(32'(pcl), 32'h0000_0001);
		cmp(32'(pcv), {8'h00, 24'h10_0000 | {14'h0000, num, 2'b00}});
		cmp(32'(kind), 32'(k));
		cmp(32'(vnum), 32'(num));
		cmp(32'(ack), 32'(k == 2'b01 && num != 8'h07));
	endtask
	task automatic step(input logic op);
		@(posedge clk);
		done <= 1'b1;
		ccrop <= op;
		@(posedge clk);
		done <= 1'b0;
		ccrop <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk);
			cmp(32'(vrd), 32'h0000_0000);
		end
	endtask
	initial begin
		#100000;
		failures++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		run_exc(8'h00, 2'b00);
		rd(`EPVU_OFF_SYSCTL, 32'h0000_0009, 1'b0);
		rd(`EPVU_OFF_MODECTL, 32'h0000_0000, 1'b0);
		cmp(32'({exten, romen, ramen}), 32'h0000_0003);
		irq_r <= 8'h04;
		idle(6);
		step(1'b0);
		idle(5);
		step(1'b1);
		idle(5);
		@(posedge clk);
		mask <= 1'b1;
		step(1'b0);
		idle(5);
		@(posedge clk);
		mask <= 1'b0;
		step(1'b0);
		run_exc(8'h12, 2'b01);
		// skip the ack edge so the source model does not race this update
		repeat (2) @(posedge clk);
		irq_r <= 8'h22;
		trap <= 1'b1;
		tnum <= 2'b01;
		done <= 1'b1;
		@(posedge clk);
		trap <= 1'b0;
		done <= 1'b0;
		run_exc(8'h11, 2'b01);
		run_exc(8'h15, 2'b01);
		run_exc(8'h09, 2'b10);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			trap <= 1'b1;
			tnum <= 2'(i);
			lat <= 4'(i * 3);
			@(posedge clk);
			trap <= 1'b0;
			run_exc(8'(8 + i), 2'b10);
		end
		wr(`EPVU_OFF_SYSCTL, 32'h0000_0034);
		rd(`EPVU_OFF_SYSCTL, 32'h0000_001c, 1'b0);
		cmp(32'({ramen, imode}), 32'h0000_0001);
		@(posedge clk);
		nmi <= 1'b1;
		step(1'b0);
		run_exc(8'h07, 2'b01);
		@(posedge clk);
		nmi <= 1'b0;
		step(1'b0);
		idle(6);
		@(posedge clk);
		pirq_r <= 8'h08;
		step(1'b0);
		run_exc(8'h1b, 2'b01);
		rd(12'h010, 32'h0000_0000, 1'b1);
		wr(`EPVU_OFF_PORTFN1, 32'h0000_0007);
		rd(`EPVU_OFF_PORTFN1, 32'h0000_0007, 1'b0);
		cmp(32'(aoe), 32'h0000_0000);
		wr(`EPVU_OFF_MODECTL, 32'h0000_0080);
		rd(`EPVU_OFF_MODECTL, 32'h0000_0080, 1'b0);
		cmp(32'({exten, aoe}), 32'h0000_000f);
		cmp(32'({dben, bcen}), 32'h0000_0003);
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		run_exc(8'h00, 2'b00);
		rd(`EPVU_OFF_SYSCTL, 32'h0000_0001, 1'b0);
		cmp(32'({exten, ramen}), 32'h0000_0001);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (3) @(posedge clk);
		pin_n <= 1'b1;
		run_exc(8'h00, 2'b00);
		rd(`EPVU_OFF_SYSCTL, 32'h0000_0009, 1'b0);
		final_report();
	end
endmodule
